/* File: src/ccd_defines.svh */
// Purpose : Offsets, field positions, reset values and counts of the clock control block
// Assumes : Included by its bare name; one aligned 32-bit word per register
// Notes   : Byte address of a register is four times its index
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CCD_PC_IDX         10'h0C4
`define CCD_STATUS_IDX     10'h0C5
`define CCD_XF_IDX         10'h091

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCD_PC_DIV_MSB     7
`define CCD_PC_DIV_LSB     6
`define CCD_PC_AUTO_BIT    5
`define CCD_PC_XOFF_BIT    3
`define CCD_XF_SRC_BIT     3
`define CCD_XF_RING_BIT    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCD_SRC_RST        1'b1
`define CCD_STABLE_RST     1'b1

// ----------------------------------------------------------------
// Last count of each machine cycle (clocks minus one) and warm-up count
// ----------------------------------------------------------------
`define CCD_CLKS_DIV4      10'h0003
`define CCD_CLKS_DIV64     10'h003F
`define CCD_CLKS_DIV1024   10'h03FF
`define CCD_WARMUP_CLKS    65536

`endif

/* File: src/ccd_pkg.sv */
// Purpose : Types shared by the clock control block
// Assumes : Constants live in ccd_defines.svh
// Notes   : Enum order matches the two-bit divider code
package ccd_pkg;

    // Divider code: 00 reserved, 01 four, 10 sixty-four, 11 1024 clocks
    typedef enum logic [1:0] {
        CCD_DIV_RSVD,
        CCD_DIV_4,
        CCD_DIV_64,
        CCD_DIV_1024
    } ccd_div_t;

endpackage : ccd_pkg

/* File: src/ccd_warmup.sv */
// Purpose : Crystal warm-up counter producing the crystal-stable flag
// Assumes : osc_ready already synchronised to clk
// Notes   : Flag drops while the amplifier is off
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_warmup #(
    parameter int WARMUP_CLKS = `CCD_WARMUP_CLKS
) (
    input  wire logic clk,       // Crystal-rate core clock
    input  wire logic rst_b,     // Async reset, active low
    input  wire logic amp_off,   // Crystal amplifier switched off
    input  wire logic osc_ready, // Oscillator has started
    output logic      stable     // Crystal ready for use
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (WARMUP_CLKS < 2 || WARMUP_CLKS > 131072) begin : g_bad_warmup
        $error("WARMUP_CLKS out of range");
    end

    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;
    logic        stable_reg;
    logic        stable_next;

    wire  [16:0] last_cnt = 17'(WARMUP_CLKS - 1);
    wire         counting = !amp_off && osc_ready && !stable_reg;

    // Count clocks after startup, then raise the flag
    always_comb begin
        cnt_next    = cnt_reg;
        stable_next = stable_reg;
        if (amp_off) begin
            cnt_next    = 17'h0_0000;
            stable_next = 1'b0;
        end else if (counting) begin
            if (cnt_reg == last_cnt) begin
                stable_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 17'h0_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg    <= 17'h0_0000;
            stable_reg <= `CCD_STABLE_RST;
        end else begin
            cnt_reg    <= cnt_next;
            stable_reg <= stable_next;
        end
    end

    assign stable = stable_reg;

endmodule : ccd_warmup

/* File: src/ccd_top.sv */
// Purpose : Machine-cycle divider, automatic return and clock source control
// Assumes : Interrupt and serial inputs come from logic on CORE_CLK
// Notes   : CORE_CLK stands for the crystal clock; the clock mux itself is outside
//
// Functional notes
// - Divider code 01 four clocks (reset), 10 sixty-four, 11 1024, 00 reserved.
// - A new divider selection governs only after one further machine cycle.
// - The machine-cycle tick paces every function, timers included.
// - Slow codes accepted only from code 01; software returns to 01 first.
// - Writing code 01 from a slow rate always restores four clocks.
// - Auto-return enable, control bit 5, makes enabled external interrupts force four clocks.
// - External interrupt triggers return only if it could actually be taken now.
// - With auto-return, enabled receiver start-bit edge forces four clocks.
// - With auto-return, a write to either transmit buffer forces four clocks.
// - Auto-return restores only the divider, never the clock source.
// - Status bits 7..5 show power-fail, high, low service in progress.
// - Status bits 0 and 1 show port 0 receive and transmit activity.
// - Status bits 2 and 3 show port 1 receive and transmit activity.
// - Source select bit 3: 1 crystal (reset), 0 internal ring.
// - Read-only bit 2 reports active source: 1 ring, 0 crystal.
// - Crystal-off bit, control bit 3, settable only while ring is selected.
// - After crystal-off clears, count warm-up clocks past startup, then flag stable.
// - Stable flag resets to 1; select 0 to 1 needs stable and amplifier on.
// - Power control at C4h, status at C5h, extended flags at 91h.
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_top #(
    parameter int N_EXT       = 6,                // External interrupt sources
    parameter int WARMUP_CLKS = `CCD_WARMUP_CLKS  // Crystal warm-up clocks
) (
    input  wire logic             CORE_CLK,      // Core clock, 100 MHz
    input  wire logic             RST_B,         // Async reset, active low
    input  wire logic             PSEL,          // APB select
    input  wire logic             PENABLE,       // APB access phase
    input  wire logic             PWRITE,        // APB write
    input  wire logic [11:0]      PADDR,         // APB byte address
    input  wire logic [31:0]      PWDATA,        // APB write data
    output logic      [31:0]      PRDATA,        // APB read data
    output logic                  PREADY,        // APB ready
    output logic                  PSLVERR,       // APB error, unmapped
    input  wire logic [N_EXT-1:0] EXT_IRQ_REQ,   // Enabled, valid external requests
    input  wire logic [N_EXT-1:0] EXT_IRQ_HIGH,  // Source has high priority
    input  wire logic             PF_ACTIVE,     // Power-fail service running
    input  wire logic             HIGH_ACTIVE,   // High-level service running
    input  wire logic             LOW_ACTIVE,    // Low-level service running
    input  wire logic [1:0]       RX_EN,         // Receiver enabled per port
    input  wire logic [1:0]       RX_START,      // Start-bit leading edge pulse
    input  wire logic [1:0]       TX_LOAD,       // Transmit buffer write pulse
    input  wire logic [1:0]       RX_BUSY,       // Word reception per port
    input  wire logic [1:0]       TX_BUSY,       // Shifting out per port
    input  wire logic             XTAL_STARTED,  // Oscillator startup done, async
    output logic                  MC_TICK,       // Machine-cycle pulse
    output logic      [1:0]       DIV_ACTIVE,    // Divider code in force
    output logic                  RING_SEL,      // Core runs from ring
    output logic                  XTAL_AMP_OFF   // Crystal amplifier off
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (N_EXT < 1 || N_EXT > 16) begin : g_bad_next
        $error("N_EXT out of range");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ccd_pkg::ccd_div_t divider_sel_reg;
    ccd_pkg::ccd_div_t divider_sel_next;
    ccd_pkg::ccd_div_t stage_div_reg;
    ccd_pkg::ccd_div_t stage_div_next;
    ccd_pkg::ccd_div_t active_div_reg;
    ccd_pkg::ccd_div_t active_div_next;
    logic        auto_return_en_reg;
    logic        auto_return_en_next;
    logic        crystal_amp_off_reg;
    logic        crystal_amp_off_next;
    logic        clock_source_sel_reg;
    logic        clock_source_sel_next;
    logic        stage_src_reg;
    logic        stage_src_next;
    logic        ring_active_reg;
    logic        ring_active_next;
    logic [9:0]  cnt_reg;
    logic [9:0]  cnt_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        xtal_sync1_reg;
    logic        xtal_sync2_reg;
    logic        crystal_stable;
    logic [N_EXT-1:0] ext_go;
    logic [1:0]  ser_go;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire       aligned  = PADDR[1:0] == 2'h0;
    wire       sel_pc   = aligned && PADDR[11:2] == `CCD_PC_IDX;
    wire       sel_stat = aligned && PADDR[11:2] == `CCD_STATUS_IDX;
    wire       sel_xf   = aligned && PADDR[11:2] == `CCD_XF_IDX;
    wire       mapped   = sel_pc || sel_stat || sel_xf;
    wire       access   = PSEL && PENABLE;
    wire       setup    = PSEL && !PENABLE;
    wire       wr_ok    = access && PWRITE && mapped;
    wire       wr_pc    = wr_ok && sel_pc;
    wire       wr_xf    = wr_ok && sel_xf;

    // Write data fields
    wire [1:0] wr_div   = PWDATA[`CCD_PC_DIV_MSB:`CCD_PC_DIV_LSB];
    wire       wr_auto  = PWDATA[`CCD_PC_AUTO_BIT];
    wire       wr_xoff  = PWDATA[`CCD_PC_XOFF_BIT];
    wire       wr_src   = PWDATA[`CCD_XF_SRC_BIT];

    // Zero-wait slave; error only on unmapped access
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;
    assign PRDATA  = prdata_reg;

    // ----------------------------------------------------------------
    // Divider write acceptance
    // ----------------------------------------------------------------
    wire div_is_fast = wr_div == 2'(ccd_pkg::CCD_DIV_4);
    wire div_is_slow = wr_div == 2'(ccd_pkg::CCD_DIV_64) || wr_div == 2'(ccd_pkg::CCD_DIV_1024);
    wire from_fast   = divider_sel_reg == ccd_pkg::CCD_DIV_4;
    wire div_accept  = wr_pc && (div_is_fast
                                  || (div_is_slow && from_fast));

    // ----------------------------------------------------------------
    // Clock source write acceptance
    // ----------------------------------------------------------------
    wire src_raise   = wr_src && !clock_source_sel_reg;
    wire src_accept  = wr_xf && (!src_raise
                                   || (crystal_stable && !crystal_amp_off_reg));
    wire xoff_accept = wr_pc && (!wr_xoff || !clock_source_sel_reg);

    // ----------------------------------------------------------------
    // Automatic return sources
    // ----------------------------------------------------------------
    // External sources: only those that would be taken now
    genvar gi;
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_ext
            assign ext_go[gi] = EXT_IRQ_REQ[gi]
                && (EXT_IRQ_HIGH[gi] ? !(PF_ACTIVE || HIGH_ACTIVE)
                                     : !(PF_ACTIVE || HIGH_ACTIVE || LOW_ACTIVE));
        end
        // Serial ports: start-bit edge with receiver on, or buffer load
        for (gi = 0; gi < 2; gi++) begin : g_ser
            assign ser_go[gi] = (RX_EN[gi] && RX_START[gi])
                                || TX_LOAD[gi];
        end
    endgenerate

    wire auto_return = auto_return_en_reg && ((|ext_go) || (|ser_go));

    // ----------------------------------------------------------------
    // Machine-cycle tick
    // ----------------------------------------------------------------
    // Last count of the machine cycle for the code in force
    wire [9:0] last_cnt =
        (active_div_reg == ccd_pkg::CCD_DIV_1024) ? `CCD_CLKS_DIV1024 :
        (active_div_reg == ccd_pkg::CCD_DIV_64)   ? `CCD_CLKS_DIV64   :
                                                    `CCD_CLKS_DIV4;
    wire       tick     = cnt_reg == last_cnt;

    assign MC_TICK    = tick;
    assign DIV_ACTIVE = 2'(active_div_reg);
    assign RING_SEL   = ring_active_reg;
    assign XTAL_AMP_OFF = crystal_amp_off_reg;

    // ----------------------------------------------------------------
    // Crystal startup synchroniser and warm-up
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            xtal_sync1_reg <= 1'b0;
            xtal_sync2_reg <= 1'b0;
        end else begin
            xtal_sync1_reg <= XTAL_STARTED;
            xtal_sync2_reg <= xtal_sync1_reg;
        end
    end

    // Counts warm-up clocks once amplifier is on and started
    ccd_warmup #(
        .WARMUP_CLKS (WARMUP_CLKS)
    ) u_warmup (
        .clk       (CORE_CLK),
        .rst_b     (RST_B),
        .amp_off   (crystal_amp_off_reg),
        .osc_ready (xtal_sync2_reg),
        .stable    (crystal_stable)
    );

    // ----------------------------------------------------------------
    // Control register next state
    // ----------------------------------------------------------------
    // Power control fields; auto-return wins over a same-cycle write
    always_comb begin
        divider_sel_next     = divider_sel_reg;
        auto_return_en_next  = auto_return_en_reg;
        crystal_amp_off_next = crystal_amp_off_reg;
        if (div_accept) begin
            divider_sel_next = ccd_pkg::ccd_div_t'(wr_div);
        end
        if (auto_return) begin
            divider_sel_next = ccd_pkg::CCD_DIV_4;
        end
        if (wr_pc) begin
            auto_return_en_next = wr_auto;
        end
        if (xoff_accept) begin
            crystal_amp_off_next = wr_xoff;
        end
    end

    // Source select; auto-return leaves it alone
    always_comb begin
        clock_source_sel_next = clock_source_sel_reg;
        if (src_accept) begin
            clock_source_sel_next = wr_src;
        end
    end

    // ----------------------------------------------------------------
    // Application at machine-cycle boundaries; auto-return forces four clocks at once
    // ----------------------------------------------------------------
    // Selection staged at one tick, applied at the next
    always_comb begin
        stage_div_next   = stage_div_reg;
        active_div_next  = active_div_reg;
        stage_src_next   = stage_src_reg;
        ring_active_next = ring_active_reg;
        cnt_next         = tick ? 10'h000 : cnt_reg + 10'h001;
        if (tick) begin
            stage_div_next   = divider_sel_reg;
            active_div_next  = stage_div_reg;
            stage_src_next   = clock_source_sel_reg;
            ring_active_next = !stage_src_reg;
        end
        if (auto_return) begin
            stage_div_next  = ccd_pkg::CCD_DIV_4;
            active_div_next = ccd_pkg::CCD_DIV_4;
            if (active_div_reg != ccd_pkg::CCD_DIV_4) begin
                cnt_next = 10'h000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup phase
    // ----------------------------------------------------------------
    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = 32'h0000_0000;
            if (sel_pc) begin
                prdata_next[`CCD_PC_DIV_MSB:`CCD_PC_DIV_LSB] = 2'(divider_sel_reg);
                prdata_next[`CCD_PC_AUTO_BIT] = auto_return_en_reg;
                prdata_next[`CCD_PC_XOFF_BIT] = crystal_amp_off_reg;
            end else if (sel_stat) begin
                prdata_next[7:5] = {PF_ACTIVE, HIGH_ACTIVE, LOW_ACTIVE};
                prdata_next[4]   = crystal_stable;
                prdata_next[3:0] = {TX_BUSY[1], RX_BUSY[1], TX_BUSY[0], RX_BUSY[0]};
            end else if (sel_xf) begin
                prdata_next[`CCD_XF_SRC_BIT]  = clock_source_sel_reg;
                prdata_next[`CCD_XF_RING_BIT] = ring_active_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Software-visible control
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            divider_sel_reg      <= ccd_pkg::CCD_DIV_4;
            auto_return_en_reg   <= 1'b0;
            crystal_amp_off_reg  <= 1'b0;
            clock_source_sel_reg <= `CCD_SRC_RST;
        end else begin
            divider_sel_reg      <= divider_sel_next;
            auto_return_en_reg   <= auto_return_en_next;
            crystal_amp_off_reg  <= crystal_amp_off_next;
            clock_source_sel_reg <= clock_source_sel_next;
        end
    end

    // Applied divider and source, cycle counter
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stage_div_reg   <= ccd_pkg::CCD_DIV_4;
            active_div_reg  <= ccd_pkg::CCD_DIV_4;
            stage_src_reg   <= `CCD_SRC_RST;
            ring_active_reg <= 1'b0;
            cnt_reg         <= 10'h000;
        end else begin
            stage_div_reg   <= stage_div_next;
            active_div_reg  <= active_div_next;
            stage_src_reg   <= stage_src_next;
            ring_active_reg <= ring_active_next;
            cnt_reg         <= cnt_next;
        end
    end

    // Read data register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

endmodule : ccd_top

/* File: dv/ccd_osc_model.sv */
// Purpose : Oscillator side model raising startup-done
// Assumes : Amplifier off stops oscillation at once
// Notes   : START_CLKS is a plain stand-in startup time
`timescale 1ns/1ps
module ccd_osc_model #(
    parameter int START_CLKS = 5
) (
    input  wire logic clk,     // Crystal clock
    input  wire logic rst_b,   // Reset, active low
    input  wire logic amp_off, // Amplifier off
    output logic      started  // Oscillation up
);
    int cnt;
    // Startup delay, restarted while the amplifier is off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cnt <= 0;
        else if (amp_off) cnt <= 0;
        else if (cnt < START_CLKS) cnt <= cnt + 1;
    end
    assign started = (cnt == START_CLKS);
endmodule : ccd_osc_model

/* File: dv/ccd_top_asserts.sv */
// Purpose : Port-level checks of the clock control block
// Assumes : Bound into ccd_top
// Notes   : Shadows the auto-return bit from APB writes
`timescale 1ns/1ps
`include "ccd_defines.svh"
module ccd_top_asserts #(
    parameter int N_EXT = 6
) (
    input wire logic             CORE_CLK,     // Core clock
    input wire logic             RST_B,        // Reset, active low
    input wire logic             PSEL,         // APB select
    input wire logic             PENABLE,      // APB access
    input wire logic             PWRITE,       // APB write
    input wire logic [11:0]      PADDR,        // APB address
    input wire logic [31:0]      PWDATA,       // APB write data
    input wire logic             PSLVERR,      // APB error
    input wire logic [N_EXT-1:0] EXT_IRQ_REQ,  // External requests
    input wire logic [N_EXT-1:0] EXT_IRQ_HIGH, // High priority
    input wire logic             PF_ACTIVE,    // Power-fail service
    input wire logic             HIGH_ACTIVE,  // High service
    input wire logic [1:0]       RX_EN,        // Receiver enabled
    input wire logic [1:0]       RX_START,     // Start-bit edge
    input wire logic [1:0]       TX_LOAD,      // Transmit load
    input wire logic             MC_TICK,      // Machine-cycle pulse
    input wire logic [1:0]       DIV_ACTIVE,   // Divider in force
    input wire logic             RING_SEL      // Ring in use
);
    logic       auto_reg;
    logic [1:0] div_q;
    logic [9:0] gap_reg;
    // Decode and expected machine-cycle position
    wire        pc_wr  = PSEL && PENABLE && PWRITE && PADDR == 12'h310;
    wire  [9:0] cyc    = (DIV_ACTIVE != div_q) ? 10'h000 : gap_reg;
    wire  [9:0] lim    = DIV_ACTIVE == 2'h3 ? `CCD_CLKS_DIV1024 :
                         DIV_ACTIVE == 2'h2 ? `CCD_CLKS_DIV64 : `CCD_CLKS_DIV4;
    wire        hi_req = |(EXT_IRQ_REQ & EXT_IRQ_HIGH) && !(PF_ACTIVE || HIGH_ACTIVE);
    // Shadow state
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            auto_reg <= 1'b0;
            div_q    <= 2'h1;
            gap_reg  <= 10'h000;
        end else begin
            auto_reg <= pc_wr ? PWDATA[5] : auto_reg;
            div_q    <= DIV_ACTIVE;
            gap_reg  <= MC_TICK ? 10'h000 : cyc + 10'h001;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_back4;
        ##1 DIV_ACTIVE == 2'h1;
    endsequence
    property p_tick_len; MC_TICK == (cyc == lim); endproperty
    property p_div_legal; DIV_ACTIVE != 2'h0; endproperty
    property p_slow_entry; $changed(DIV_ACTIVE) && DIV_ACTIVE[1] |-> $past(DIV_ACTIVE) == 2'h1 && $past(MC_TICK);
    endproperty
    property p_src_tick; $changed(RING_SEL) |-> $past(MC_TICK); endproperty
    property p_auto_ext; auto_reg && hi_req |-> s_back4; endproperty
    property p_auto_rx; auto_reg && |(RX_START & RX_EN) |-> s_back4; endproperty
    property p_auto_tx; auto_reg && |TX_LOAD |-> s_back4; endproperty
    property p_unaligned; PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR; endproperty
    a_tick_len: assert property (p_tick_len) else $error("machine cycle length wrong");
    a_div_legal: assert property (p_div_legal) else $error("reserved divider in force");
    a_slow_entry: assert property (p_slow_entry) else $error("bad slow entry");
    a_src_tick: assert property (p_src_tick) else $error("source changed off tick");
    a_auto_ext: assert property (p_auto_ext) else $error("no return on interrupt");
    a_auto_rx: assert property (p_auto_rx) else $error("no return on start bit");
    a_auto_tx: assert property (p_auto_tx) else $error("no return on transmit");
    a_unaligned: assert property (p_unaligned) else $error("no error on bad address");
endmodule : ccd_top_asserts

bind ccd_top ccd_top_asserts #(.N_EXT(N_EXT)) u_chk (.*);

/* File: dv/tb_cpu_clock_divider_source_control.sv */
// Purpose : Self-checking bench of the clock control block
// Assumes : Short warm-up count of 16 clocks
// Notes   : Register access over APB only
`timescale 1ns/1ps
module tb_cpu_clock_divider_source_control;
    localparam logic [11:0] ADR [5] = '{12'h310, 12'h314, 12'h244, 12'h000, 12'h312};
    localparam logic [31:0] RST [5] = '{32'h0000_0040, 32'h0000_0010, 32'h0000_0008, 32'h0, 32'h0};
    logic        CORE_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        PF_ACTIVE = 1'b0, HIGH_ACTIVE = 1'b0, LOW_ACTIVE = 1'b0;
    logic        PREADY, PSLVERR, er, MC_TICK, RING_SEL, XTAL_AMP_OFF, XTAL_STARTED;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, r;
    logic [5:0]  EXT_IRQ_REQ = 6'h00, EXT_IRQ_HIGH = 6'h00;
    logic [1:0]  RX_EN = 2'h0, RX_START = 2'h0, TX_LOAD = 2'h0, RX_BUSY = 2'h0, TX_BUSY = 2'h0;
    logic [1:0]  DIV_ACTIVE;
    int          fail_count = 0, num_checks = 0, cycles = 0, seed = 32'h6c18;

    ccd_top #(.N_EXT(6), .WARMUP_CLKS(16)) dut (.*);
    ccd_osc_model u_osc (.clk(CORE_CLK), .rst_b(RST_B), .amp_off(XTAL_AMP_OFF), .started(XTAL_STARTED));

    // Clock and hang limit
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            final_report;
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        #1;
    endtask : apb

    // Wait for n machine-cycle boundaries
    task automatic tk(input int n);
        repeat (n) begin
            do @(negedge CORE_CLK); while (MC_TICK !== 1'b1);
            @(posedge CORE_CLK);
        end
        #1;
    endtask : tk

    // One-cycle wake event, optionally made non-qualifying
    task automatic ev(input int k, input logic blk);
        logic [5:0] m;
        m = 6'h01 << ($unsigned($random(seed)) % 6);
        @(posedge CORE_CLK);
        case (k)
            0: begin
                EXT_IRQ_REQ  <= m;
                EXT_IRQ_HIGH <= m;
                HIGH_ACTIVE  <= blk;
            end
            1: begin
                RX_START <= 2'h3;
                RX_EN    <= {2{!blk}};
            end
            2: TX_LOAD <= 2'h2;
            default: begin
                EXT_IRQ_REQ <= m;
                LOW_ACTIVE  <= blk;
            end
        endcase
        @(posedge CORE_CLK);
        {EXT_IRQ_REQ, EXT_IRQ_HIGH, HIGH_ACTIVE, LOW_ACTIVE, RX_START, RX_EN, TX_LOAD} <= '0;
        #1;
    endtask : ev

    initial begin
        repeat (12) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ADR[i], 32'h0);
            chk("reset read", rd, RST[i]);
            chk("slave error", {31'h0, er}, {31'h0, i > 2});
        end
        // Live status inputs, random
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            {PF_ACTIVE, HIGH_ACTIVE, LOW_ACTIVE, RX_BUSY, TX_BUSY} <= r[6:0];
            apb(1'b0, 12'h314, 32'h0);
            chk("status", rd, {24'h0, r[6:4], 1'b1, r[1], r[3], r[0], r[2]});
        end
        {PF_ACTIVE, HIGH_ACTIVE, LOW_ACTIVE, RX_BUSY, TX_BUSY} <= 7'h00;
        // Divider codes and write restrictions
        apb(1'b1, 12'h310, 32'h0000_00C0);
        chk("div early", DIV_ACTIVE, 2'h1);
        tk(3);
        chk("div 1024", DIV_ACTIVE, 2'h3);
        apb(1'b1, 12'h310, 32'h0000_0080);
        apb(1'b0, 12'h310, 32'h0);
        chk("slow to slow", rd, 32'h0000_00C0);
        apb(1'b1, 12'h310, 32'h0000_0040);
        tk(3);
        chk("div 4", DIV_ACTIVE, 2'h1);
        apb(1'b1, 12'h310, 32'h0000_0000);
        apb(1'b0, 12'h310, 32'h0);
        chk("reserved code", rd, 32'h0000_0040);
        // Automatic return per event kind
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'h310, 32'h0000_00A0);
            tk(3);
            chk("div 64", DIV_ACTIVE, 2'h2);
            if (k != 2) begin
                ev(k, 1'b1);
                chk("blocked event", DIV_ACTIVE, 2'h2);
            end
            ev(k, 1'b0);
            chk("auto return", DIV_ACTIVE, 2'h1);
        end
        // Clock source and crystal amplifier
        apb(1'b1, 12'h310, 32'h0000_0008);
        chk("amp off refused", XTAL_AMP_OFF, 1'b0);
        apb(1'b1, 12'h244, 32'h0);
        tk(3);
        apb(1'b0, 12'h244, 32'h0);
        chk("ring read", rd, 32'h0000_0004);
        apb(1'b1, 12'h310, 32'h0000_00A8);
        chk("amp off", XTAL_AMP_OFF, 1'b1);
        apb(1'b0, 12'h314, 32'h0);
        chk("unstable", rd[4], 1'b0);
        apb(1'b1, 12'h244, 32'h0000_0008);
        tk(3);
        ev(2, 1'b0);
        chk("ring kept", {DIV_ACTIVE, RING_SEL}, 3'h3);
        apb(1'b1, 12'h310, 32'h0);
        apb(1'b0, 12'h314, 32'h0);
        chk("warming", rd[4], 1'b0);
        repeat (40) @(posedge CORE_CLK);
        apb(1'b0, 12'h314, 32'h0);
        chk("stable", rd[4], 1'b1);
        apb(1'b1, 12'h244, 32'h0000_0008);
        tk(3);
        chk("crystal back", RING_SEL, 1'b0);
        final_report;
    end
endmodule : tb_cpu_clock_divider_source_control
